// ### hw/dewc_regs.vh
`ifndef DEWC_REGS_VH
`define DEWC_REGS_VH
// byte addresses on the axi4-lite slave
`define DEWC_ADDR_BYTE_ADDRESS 5'h00
`define DEWC_ADDR_BYTE_VALUE 5'h04
`define DEWC_ADDR_MEMORY_CONTROL 5'h08
`define DEWC_ADDR_UNLOCK_PORT 5'h0c
`define DEWC_ADDR_FLAGS_TWO 5'h10
`define DEWC_ADDR_ENABLE_TWO 5'h14
`define DEWC_ADDR_PRIORITY_TWO 5'h18
// memory_control fields
`define DEWC_MC_SPACE 7
`define DEWC_MC_CFG 6
`define DEWC_MC_FAULT 3
`define DEWC_MC_ALLOW 2
`define DEWC_MC_START 1
`define DEWC_MC_READ 0
// peripheral flag/enable/priority bit for write done
`define DEWC_DONE_BIT 4
// unlock keys
`define DEWC_KEY_FIRST 8'h55
`define DEWC_KEY_SECOND 8'haa
// timing
`define DEWC_CLK_MHZ 100
`define DEWC_WRITE_TIME_US 4000
`define DEWC_PWRT_TIME_US 65000
`define DEWC_RESET_ZERO 8'h00
`endif

// ### hw/dewc_timer.v
`timescale 1ns/1ps
`default_nettype none
// one-shot down counter; busy while counting
module dewc_timer #(
	parameter integer COUNT = 16
) (
	input wire clk,
	input wire rst_n,
	input wire start,
	output wire busy,
	output reg done
);
	reg [31:0] cnt_q;
	assign busy = (cnt_q != 32'h0);
	always @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= 32'h0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				cnt_q <= COUNT;
			end else if (busy) begin
				cnt_q <= cnt_q - 32'h1;
				if (cnt_q == 32'h1) begin
					done <= 1'b1;
				end
			end
		end
	end
endmodule // dewc_timer
`default_nettype wire

// ### hw/dewc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "dewc_regs.vh"
// Summary of operation
// RQ1: software loads address and data first
// RQ2: 55h, 0AAh, then start bit, exactly
// RQ3: software masks interrupts during unlock
// RQ4: start bit refused without write allow
// RQ5: hardware never clears write allow
// RQ6: software keeps write allow mostly clear
// RQ7: registers frozen during write cycle; code freezes only byte address, byte value and memory control
// RQ8: allow and start together never start
// RQ9: completion clears start, sets done flag
// RQ10: done flag sticky until software clears
// RQ11: code protect blocks external access
// RQ12: processor access ignores code protect
// RQ13: write allow cleared at power up
// RQ14: no writes during power-up timer
// RQ15: byte addressable, one byte per write
// RQ16: software verifies by reading back
// RQ17: read bit loads data next cycle
// RQ18: unlock port reads as zero
// RQ19: start bit reads one while writing
module dewc_top #(
	parameter integer WRITE_CYCLES =
		`DEWC_WRITE_TIME_US * `DEWC_CLK_MHZ,
	parameter integer PWRT_CYCLES = `DEWC_PWRT_TIME_US * `DEWC_CLK_MHZ
) (
	input wire aclk,
	input wire aresetn,
	input wire [4:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [4:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire code_protect,
	input wire ext_req,
	input wire ext_we,
	input wire [7:0] ext_addr,
	input wire [7:0] ext_wdata,
	output reg [7:0] ext_rdata,
	output reg ext_ack,
	output reg write_done_irq
);
	reg [7:0] mem [0:255];
	reg [7:0] byte_address_q, byte_value_q;
	reg space_q, cfg_q, fault_q, allow_q, start_q;
	reg done_flag_q, done_en_q, done_pri_q;
	reg [1:0] unlock_q;
	reg [4:0] waddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg have_aw_q, have_w_q;
	reg cp_meta_q, cp_q, er_meta_q, er_q, er_prev_q;
	reg [16:0] ex_meta_q, ex_q;
	wire wr_busy, wr_fin, pwrt_busy;
	reg pwrt_go_q;
	// the write cycle, self-timed
	dewc_timer #(.COUNT(WRITE_CYCLES)) u_wr (
		.clk(aclk),
		.rst_n(aresetn),
		.start(start_q && !wr_busy && !wr_fin),
		.busy(wr_busy),
		.done(wr_fin)
	);
	dewc_timer #(.COUNT(PWRT_CYCLES)) u_pwrt (
		.clk(aclk),
		.rst_n(aresetn),
		.start(pwrt_go_q),
		.busy(pwrt_busy),
		.done()
	);
	wire do_write = have_aw_q && have_w_q && !s_axi_bvalid;
	wire wr_lane = wstrb_q[0];
	wire [7:0] wb = wdata_q[7:0];
	wire frozen = start_q; // [RQ7]
	// one access per rising request, so a slow release never repeats it
	wire ext_take = er_q && !er_prev_q;
	wire ext_wr = ext_take && ex_q[16] && !cp_q &&
		!wr_fin && !pwrt_busy;
	always @(posedge aclk) begin
		if (!aresetn) begin
			cp_meta_q <= 1'b0;
			cp_q <= 1'b0;
			er_meta_q <= 1'b0;
			er_q <= 1'b0;
			er_prev_q <= 1'b0;
			ex_meta_q <= 17'h0;
			ex_q <= 17'h0;
		end else begin
			cp_meta_q <= code_protect;
			cp_q <= cp_meta_q;
			er_meta_q <= ext_req;
			er_q <= er_meta_q;
			er_prev_q <= er_q;
			// held with the request, so it settles with it
			ex_meta_q <= {ext_we, ext_addr, ext_wdata};
			ex_q <= ex_meta_q;
		end
	end
	// axi write channel capture; either order accepted
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			have_aw_q <= 1'b0;
			have_w_q <= 1'b0;
			waddr_q <= 5'h0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			s_axi_awready <= !have_aw_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !have_w_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				have_aw_q <= 1'b1;
				waddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				have_w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				have_aw_q <= 1'b0;
				have_w_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (waddr_q <= `DEWC_ADDR_PRIORITY_TWO &&
					waddr_q[1:0] == 2'b00) ? 2'b00 : 2'b10;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// register file and write engine
	always @(posedge aclk) begin
		if (!aresetn) begin
			byte_address_q <= `DEWC_RESET_ZERO;
			byte_value_q <= `DEWC_RESET_ZERO;
			space_q <= 1'b0;
			cfg_q <= 1'b0;
			fault_q <= 1'b0;
			allow_q <= 1'b0; // [RQ13]
			start_q <= 1'b0;
			done_flag_q <= 1'b0;
			done_en_q <= 1'b0;
			done_pri_q <= 1'b0;
			unlock_q <= 2'd0;
			pwrt_go_q <= 1'b1;
			write_done_irq <= 1'b0;
		end else begin
			pwrt_go_q <= 1'b0;
			if (wr_fin) begin
				mem[byte_address_q] <= byte_value_q; // [RQ15]
				start_q <= 1'b0; // [RQ9]
			end
			if (ext_wr)
				mem[ex_q[15:8]] <= ex_q[7:0]; // [RQ11] [RQ14]
			if (do_write && wr_lane) begin
				// any other write with byte lane 0 strobed breaks the unlock order
				unlock_q <= 2'd0; // [RQ2]
				case (waddr_q)
				`DEWC_ADDR_BYTE_ADDRESS: begin
					if (!frozen)
						byte_address_q <= wb;
				end
				`DEWC_ADDR_BYTE_VALUE: begin
					if (!frozen)
						byte_value_q <= wb;
				end
				`DEWC_ADDR_UNLOCK_PORT: begin
					if (wb == `DEWC_KEY_FIRST)
						unlock_q <= 2'd1;
					else if (wb == `DEWC_KEY_SECOND && unlock_q == 2'd1)
						unlock_q <= 2'd2; // [RQ2]
				end
				`DEWC_ADDR_MEMORY_CONTROL: begin
					if (!frozen) begin
						space_q <= wb[`DEWC_MC_SPACE];
						cfg_q <= wb[`DEWC_MC_CFG];
						fault_q <= wb[`DEWC_MC_FAULT] & fault_q;
						allow_q <= wb[`DEWC_MC_ALLOW]; // [RQ5]
						// old allow only, so a joint set fails
						if (wb[`DEWC_MC_START] && allow_q && // [RQ4] [RQ8]
							unlock_q == 2'd2 && !space_q && !cfg_q &&
							!pwrt_busy) // [RQ14] [RQ2]
							start_q <= 1'b1; // [RQ19]
						if (wb[`DEWC_MC_READ] && !space_q && !cfg_q)
							byte_value_q <= mem[byte_address_q]; // [RQ17]
					end
				end
				`DEWC_ADDR_FLAGS_TWO: begin
					// set wins over a clear in the same cycle
					done_flag_q <= wb[`DEWC_DONE_BIT] & done_flag_q; // [RQ10]
				end
				`DEWC_ADDR_ENABLE_TWO: done_en_q <= wb[`DEWC_DONE_BIT];
				`DEWC_ADDR_PRIORITY_TWO: done_pri_q <= wb[`DEWC_DONE_BIT];
				default: ;
				endcase
			end
			if (wr_fin)
				done_flag_q <= 1'b1; // [RQ9] [RQ10]
			write_done_irq <= done_flag_q && done_en_q;
		end
	end
	// external programming port, gated by protection
	always @(posedge aclk) begin
		if (!aresetn) begin
			ext_ack <= 1'b0;
			ext_rdata <= 8'h00;
		end else begin
			ext_ack <= ext_take;
			if (ext_take) begin
				if (cp_q) begin
					ext_rdata <= 8'h00; // [RQ11]
				end else if (!ex_q[16]) begin
					ext_rdata <= mem[ex_q[15:8]];
				end
			end
		end
	end
	// read channel; processor reads ignore protection
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'b00;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
				s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				s_axi_rdata <= 32'h0;
				case (s_axi_araddr)
				`DEWC_ADDR_BYTE_ADDRESS:
					s_axi_rdata[7:0] <= byte_address_q;
				`DEWC_ADDR_BYTE_VALUE:
					s_axi_rdata[7:0] <= byte_value_q; // [RQ12]
				`DEWC_ADDR_MEMORY_CONTROL:
					s_axi_rdata[7:0] <= {space_q, cfg_q, 2'b00, fault_q,
						allow_q, start_q, 1'b0}; // [RQ19]
				`DEWC_ADDR_UNLOCK_PORT:
					s_axi_rdata[7:0] <= 8'h00; // [RQ18]
				`DEWC_ADDR_FLAGS_TWO:
					s_axi_rdata[`DEWC_DONE_BIT] <= done_flag_q;
				`DEWC_ADDR_ENABLE_TWO:
					s_axi_rdata[`DEWC_DONE_BIT] <= done_en_q;
				`DEWC_ADDR_PRIORITY_TWO:
					s_axi_rdata[`DEWC_DONE_BIT] <= done_pri_q;
				default:
					s_axi_rresp <= 2'b10;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // dewc_top
`default_nettype wire

// ### sim/data_eeprom_write_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module data_eeprom_write_control_tb_top;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic code_protect = 0, ext_req = 0, ext_we = 0;
	logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic [7:0] ext_addr = 0, ext_wdata = 0, ext_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, ext_ack, write_done_irq;
	logic [22:0] rows [6] = '{{5'h00, 8'h5a, 8'h5a, 2'h0},
		{5'h04, 8'h3c, 8'h3c, 2'h0}, {5'h14, 8'h10, 8'h10, 2'h0},
		{5'h18, 8'h10, 8'h10, 2'h0}, {5'h0c, 8'h55, 8'h00, 2'h0},
		{5'h1c, 8'h00, 8'h00, 2'h2}};
	int n_errors = 0, checks = 0, i, n;
	// long counts shortened so the run stays brief
	dewc_top #(.WRITE_CYCLES(40), .PWRT_CYCLES(64)) dewc_top_inst (.aclk,
		.aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .code_protect,
		.ext_req, .ext_we, .ext_addr, .ext_wdata, .ext_rdata, .ext_ack,
		.write_done_irq);
	always #5 aclk = ~aclk;
	task conclude;
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task to;
		n_errors++;
		conclude();
	endtask
	task ck(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// one bus transfer; valids drop only at their own handshake edge
	task ax(input logic w, input logic [4:0] a, input logic [7:0] d);
		int k;
		k = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, 24'h0, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
			s_axi_rready} <= w ? 5'b11100 : 5'b00011;
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_arready) s_axi_arvalid <= 0;
			rd = s_axi_rdata;
			rr = w ? s_axi_bresp : s_axi_rresp;
		end while (!(w ? s_axi_bvalid : s_axi_rvalid) && k < 40);
		{s_axi_bready, s_axi_rready} <= 2'b00;
		if (k >= 40) to();
		@(posedge aclk);
	endtask
	task ex(input logic we, input logic [7:0] a, input logic [7:0] d);
		int k;
		k = 0;
		{ext_we, ext_addr, ext_wdata, ext_req} <= {we, a, d, 1'b1};
		do begin
			@(posedge aclk);
			k++;
		end while (!ext_ack && k < 20);
		rd = ext_rdata;
		ext_req <= 0;
		if (k >= 20) to();
		repeat (6) @(posedge aclk);
	endtask
	task ul;
		ax(1, 5'h0c, 8'h55);
		ax(1, 5'h0c, 8'haa);
	endtask
	task mc(input logic [7:0] d, input logic [31:0] e);
		ax(1, 5'h08, d);
		ax(0, 5'h08, 0);
		ck(rd[1], e);
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		ax(0, 5'h08, 0);
		ck(rd, 0);
		ax(1, 5'h08, 8'h04);
		ul();
		mc(8'h06, 0);
		for (i = 0; i < 6; i++) begin
			ax(1, rows[i][22:18], rows[i][17:10]);
			ck(rr, rows[i][1:0]);
			ax(0, rows[i][22:18], 0);
			ck({rr, rd[7:0]}, {rows[i][1:0], rows[i][9:2]});
		end
		repeat (64) @(posedge aclk);
		ax(1, 5'h08, 0);
		ul();
		mc(8'h02, 0);
		ax(1, 5'h08, 0);
		ul();
		mc(8'h06, 0);
		ax(1, 5'h08, 8'h04);
		ax(1, 5'h0c, 8'haa);
		ax(1, 5'h0c, 8'h55);
		mc(8'h06, 0);
		ax(1, 5'h00, 8'h21);
		ax(1, 5'h04, 8'hc3);
		ul();
		mc(8'h06, 1);
		ax(1, 5'h04, 8'h99);
		ax(1, 5'h08, 8'h00);
		ax(0, 5'h04, 0);
		ck(rd, 32'hc3);
		n = 0;
		do begin
			ax(0, 5'h08, 0);
			n++;
		end while (rd[1] !== 1'b0 && n < 20);
		if (n >= 20) to();
		ck(rd, 32'h04);
		ax(1, 5'h10, 8'h10);
		ax(0, 5'h10, 0);
		ck(rd, 32'h10);
		ck(write_done_irq, 1);
		ax(1, 5'h10, 8'h00);
		ck(write_done_irq, 0);
		ax(1, 5'h04, 0);
		code_protect <= 1;
		ax(1, 5'h08, 8'h05);
		ax(0, 5'h04, 0);
		ck(rd, 32'hc3);
		// space or config selected: read strobe must not load
		ax(1, 5'h04, 0);
		ax(1, 5'h08, 8'hc4);
		ax(1, 5'h08, 8'hc5);
		ax(0, 5'h04, 0);
		ck(rd, 0);
		ex(1, 8'h21, 8'h11);
		ex(0, 8'h21, 0);
		ck(rd, 0);
		code_protect <= 0;
		repeat (4) @(posedge aclk);
		ex(0, 8'h21, 0);
		ck(rd, 32'hc3);
		// second reset in mid-run, with write allow still set
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		ax(0, 5'h08, 0);
		ck(rd, 0);
		conclude();
	end
endmodule // data_eeprom_write_control_tb_top
`default_nettype wire

// ### sim/dewc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dewc_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic code_protect,
	input wire logic ext_req,
	input wire logic [7:0] ext_rdata,
	input wire logic ext_ack,
	input wire logic write_done_irq
);
	logic [4:0] ra_q = 5'h00;
	always @(posedge aclk) begin
		if (s_axi_arvalid && s_axi_arready)
			ra_q <= s_axi_araddr;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
	AST_RESP: assert property (s_axi_rvalid |-> (s_axi_rresp == 2'h2) ==
		(ra_q > 5'h18 || ra_q[1:0] != 2'h0)) else $error("bad read response");
	AST_UNLK: assert property (s_axi_rvalid && ra_q == 5'h0c
		|-> s_axi_rdata == 32'h0) else $error("unlock port read not zero");
	AST_ACKP: assert property (ext_ack |=> !ext_ack)
		else $error("external ack longer than one cycle");
	AST_ACKREQ: assert property ($rose(ext_ack) |-> $past(ext_req, 2))
		else $error("external ack without request");
	AST_CPZ: assert property (ext_ack && code_protect &&
		$past(code_protect, 3) |-> ext_rdata == 8'h00)
		else $error("protected external read leaked data");
	AST_IRQF: assert property ($fell(write_done_irq)
		|-> $past(s_axi_bvalid)) else $error("done flag cleared by itself");
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	cover property ($rose(write_done_irq));
	cover property (ext_ack && code_protect);
endmodule // dewc_chk
bind dewc_top dewc_chk dewc_chk_inst (.aclk, .aresetn, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .s_axi_bvalid, .s_axi_bready, .code_protect, .ext_req,
	.ext_rdata, .ext_ack, .write_done_irq);
`default_nettype wire
